// file: verilog/mfr_cfg.svh
/*
 * Constants of the multi-line flash read engine: opcodes, phase lengths,
 * dummy-count defaults and the mode nibble that keeps continuous read.
 * Assumes it is included by bare name from the engine's module file; the package does not include it.
 */
`ifndef MFR_CFG_SVH
`define MFR_CFG_SVH

// Read opcodes decoded by the engine.
`define MFR_OP_DUAL_OUT      8'h3b
`define MFR_OP_DUAL_OUT_4B   8'h3c
`define MFR_OP_QUAD_OUT      8'h6b
`define MFR_OP_QUAD_OUT_4B   8'h6c
`define MFR_OP_QUAD_IO       8'heb
`define MFR_OP_QUAD_IO_4B    8'hec

// Rising edges in each address phase.
`define MFR_ADDR_1L_3B       6'h18
`define MFR_ADDR_1L_4B       6'h20
`define MFR_ADDR_4L_3B       6'h06
`define MFR_ADDR_4L_4B       6'h08

// Opcode length in single-line clocks.
`define MFR_CMD_CLKS         6'h08

// Dummy defaults; a configured count of zero selects them (for quad I/O, any count below two).
`define MFR_DUMMY_OUT_DEF    4'h8
`define MFR_DUMMY_QIO_DEF    4'h6

// Mode-bit clocks inside the quad-I/O dummy period.
`define MFR_MODE_CLKS        4'h2
// Upper mode nibble that keeps continuous read.
`define MFR_CONT_NIBBLE      4'ha

// Fill byte driven when the buffer runs dry.
`define MFR_UNDERRUN_BYTE    8'hff

`endif

// file: verilog/mfr_pkg.sv
/*
 * Types of the multi-line flash read engine.
 * Assumes mfr_cfg.svh sits beside it on the include path.
 */
`default_nettype none

package mfr_pkg;

    // Kind of read being served.
    typedef enum logic [1:0] {
        MFR_KIND_DUAL,
        MFR_KIND_QUAD,
        MFR_KIND_QIO
    } mfr_kind_t;

    // Sequencer states.
    typedef enum logic [2:0] {
        MFR_ST_IDLE,
        MFR_ST_CMD,
        MFR_ST_ADDR,
        MFR_ST_DUMMY,
        MFR_ST_DATA,
        MFR_ST_IGNORE
    } mfr_state_t;

    // Read configuration presented by the device's status logic.
    typedef struct packed {
        logic       extended_address_flag;
        logic [3:0] dummy_out;
        logic [3:0] dummy_qio;
    } mfr_rd_cfg_t;

endpackage

`default_nettype wire

// file: verilog/mfr_engine.sv
/*
 * Read-command front end of a serial flash: dual-output, quad-output and
 * quad-I/O reads with continuous-read mode, plus the byte buffer that sits
 * between the array port and the serial shifter.
 * Assumes the host clock and select arrive asynchronously and are sampled
 * by ref_clk_in, which must run at least four times faster than the link
 * clock; the array port and status inputs are synchronous to ref_clk_in.
 */
// Summary of operation
// - 3Bh takes 3 or 4 address bytes by extended flag; 3Ch always 4.
// - Dual-output opcode, address, dummy on IO0 per rise; dummy default 8.
// - Dual-output data: two bits per fall, MSB on IO1, next on IO0.
// - 6Bh takes 3 or 4 address bytes by extended flag; 6Ch always 4.
// - Quad-output opcode, address, dummy on IO0 per rise; dummy default 8.
// - Quad data: four bits per fall, MSB on IO3 down to IO0.
// - EBh takes 3 or 4 address bytes by extended flag; ECh always 4.
// - Quad-I/O address and dummy four bits per rise, MSB on IO3; default 6.
// - Address increments after each byte and wraps from top to zero.
// - Select high ends the read; device stops driving data.
// - Reads arriving while write in progress are ignored entirely.
// - First two quad-I/O dummy clocks carry mode byte; upper nibble counts.
// - Upper nibble 1010 enters continuous read; next read starts at address.
// - Any other nibble leaves continuous read; next read needs opcode again.
// - Configured quad-I/O dummy count includes the two mode clocks.
// - Outside continuous read the quad-I/O opcode comes on IO0 in eight clocks.
`timescale 1ns/10ps
`default_nettype none
`include "mfr_cfg.svh"

module mfr_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             ref_clk_in,
    input  wire logic             rst_b_in,
    input  wire logic             flush_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0]    wr_ptr;
    logic [PW-1:0]    rd_ptr;
    logic [PW:0]      count;
    logic [PW:0]      next_count;
    logic             push;
    logic             pop;

    // Ready is registered, so it is computed from the count that will stand next.
    assign push          = in_valid_in & in_ready_out;
    assign pop           = out_valid_out & out_ready_in;
    assign out_valid_out = (count != '0);
    assign out_data_out  = mem[rd_ptr];
    assign next_count    = flush_in ? '0 : count + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};

    // Pointers, count and registered ready; flush empties and blocks filling.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            wr_ptr       <= '0;
            rd_ptr       <= '0;
            count        <= '0;
            in_ready_out <= 1'b0;
        end else begin
            wr_ptr       <= flush_in ? '0 : wr_ptr + PW'(push);
            rd_ptr       <= flush_in ? '0 : rd_ptr + PW'(pop);
            count        <= next_count;
            in_ready_out <= !flush_in && (next_count < (PW+1)'(DEPTH));
        end
    end

    // Storage needs no reset; only written words are ever read.
    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end
endmodule

module mfr_engine
    import mfr_pkg::*;
#(
    parameter int ADDR_W     = 24,
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic              ref_clk_in,
    input  wire logic              rst_b_in,
    input  wire logic              sck_in,
    input  wire logic              cs_b_in,
    input  wire logic [3:0]        io_in,
    output logic      [3:0]        io_out,
    output logic      [3:0]        io_oe_out,
    input  wire logic              write_in_progress_flag_in,
    input  wire mfr_rd_cfg_t       cfg_in,
    output logic      [ADDR_W-1:0] arr_addr_out,
    input  wire logic              arr_valid_in,
    input  wire logic [7:0]        arr_data_in,
    output logic                   arr_ready_out,
    output logic                   continuous_read_mode_out,
    output logic      [3:0]        mode_bits_top_out
);
    mfr_state_t  state;
    mfr_kind_t   kind;
    mfr_kind_t   dec_kind;
    logic        sck_s1, sck_s2, sck_s3;
    logic        cs_s1, cs_s2;
    logic [3:0]  io_s1, io_s2;
    logic        rise, fall;
    logic [5:0]  bit_cnt;
    logic [5:0]  addr_rises;
    logic [3:0]  dummy_len;
    logic [6:0]  cmd_sr;
    logic [7:0]  opcode;
    logic        dec_valid;
    logic        dec_addr4;
    logic [31:0] addr_sr;
    logic [31:0] next_addr;
    logic        addr_done;
    logic        cont_addr4;
    logic        fifo_flush;
    logic        fifo_valid;
    logic [7:0]  fifo_data;
    logic        pop;
    logic [7:0]  byte_sr;
    logic [1:0]  slot;
    logic        arr_fire;

    // Two flip-flops on every pin input; the third sck stage only feeds edge finding.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            cs_s1  <= 1'b1;
            cs_s2  <= 1'b1;
            io_s1  <= 4'h0;
            io_s2  <= 4'h0;
        end else begin
            sck_s1 <= sck_in;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            cs_s1  <= cs_b_in;
            cs_s2  <= cs_s1;
            io_s1  <= io_in;
            io_s2  <= io_s1;
        end
    end

    assign rise = sck_s2 & ~sck_s3;
    assign fall = ~sck_s2 & sck_s3;

    // Opcode decode on the eighth single-line clock, bit just arriving included.
    always_comb begin
        opcode    = {cmd_sr, io_s2[0]};
        dec_valid = 1'b1;
        dec_kind  = MFR_KIND_DUAL;
        dec_addr4 = cfg_in.extended_address_flag;
        unique case (opcode)
            `MFR_OP_DUAL_OUT:    dec_kind = MFR_KIND_DUAL;
            `MFR_OP_DUAL_OUT_4B: dec_addr4 = 1'b1;
            `MFR_OP_QUAD_OUT:    dec_kind = MFR_KIND_QUAD;
            `MFR_OP_QUAD_OUT_4B: begin
                dec_kind  = MFR_KIND_QUAD;
                dec_addr4 = 1'b1;
            end
            `MFR_OP_QUAD_IO:     dec_kind = MFR_KIND_QIO;
            `MFR_OP_QUAD_IO_4B: begin
                dec_kind  = MFR_KIND_QIO;
                dec_addr4 = 1'b1;
            end
            default:             dec_valid = 1'b0;
        endcase
    end

    // Address shifts one bit per rise on IO0, or a nibble with MSB on IO3.
    assign next_addr = (kind == MFR_KIND_QIO) ? {addr_sr[27:0], io_s2}
                                              : {addr_sr[30:0], io_s2[0]};
    assign addr_done = (state == MFR_ST_ADDR) && rise && (bit_cnt == addr_rises - 6'h01);

    // Phase sequencer; select high aborts whatever is under way.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            state      <= MFR_ST_IDLE;
            kind       <= MFR_KIND_DUAL;
            bit_cnt    <= 6'h00;
            addr_rises <= `MFR_ADDR_1L_3B;
            dummy_len  <= `MFR_DUMMY_OUT_DEF;
            cmd_sr     <= 7'h00;
            addr_sr    <= 32'h0000_0000;
        end else if (cs_s2) begin
            state   <= MFR_ST_IDLE;
            bit_cnt <= 6'h00;
        end else begin
            unique case (state)
                MFR_ST_IDLE: begin
                    bit_cnt <= 6'h00;
                    if (continuous_read_mode_out) begin
                        // Continuous read skips the opcode and starts at the address.
                        kind       <= MFR_KIND_QIO;
                        addr_rises <= cont_addr4 ? `MFR_ADDR_4L_4B : `MFR_ADDR_4L_3B;
                        state      <= write_in_progress_flag_in ? MFR_ST_IGNORE : MFR_ST_ADDR;
                    end else begin
                        state <= MFR_ST_CMD;
                    end
                end
                MFR_ST_CMD: begin
                    if (rise) begin
                        cmd_sr  <= opcode[6:0];
                        bit_cnt <= bit_cnt + 6'h01;
                        if (bit_cnt == `MFR_CMD_CLKS - 6'h01) begin
                            bit_cnt <= 6'h00;
                            kind    <= dec_kind;
                            // Busy array: drop the read; kind, address length and dummy count still load.
                            state   <= (!dec_valid || write_in_progress_flag_in) ? MFR_ST_IGNORE
                                                                                 : MFR_ST_ADDR;
                            if (dec_kind == MFR_KIND_QIO) begin
                                addr_rises <= dec_addr4 ? `MFR_ADDR_4L_4B : `MFR_ADDR_4L_3B;
                                dummy_len  <= (cfg_in.dummy_qio < `MFR_MODE_CLKS) ? `MFR_DUMMY_QIO_DEF
                                                                                  : cfg_in.dummy_qio;
                            end else begin
                                addr_rises <= dec_addr4 ? `MFR_ADDR_1L_4B : `MFR_ADDR_1L_3B;
                                dummy_len  <= (cfg_in.dummy_out == 4'h0) ? `MFR_DUMMY_OUT_DEF
                                                                         : cfg_in.dummy_out;
                            end
                        end
                    end
                end
                MFR_ST_ADDR: begin
                    if (rise) begin
                        addr_sr <= next_addr;
                        bit_cnt <= bit_cnt + 6'h01;
                        if (addr_done) begin
                            bit_cnt <= 6'h00;
                            state   <= MFR_ST_DUMMY;
                        end
                    end
                end
                MFR_ST_DUMMY: begin
                    if (rise) begin
                        bit_cnt <= bit_cnt + 6'h01;
                        // Mode clocks count inside the dummy total.
                        if (bit_cnt == {2'b00, dummy_len} - 6'h01) begin
                            state <= MFR_ST_DATA;
                        end
                    end
                end
                MFR_ST_DATA:   state <= MFR_ST_DATA;
                MFR_ST_IGNORE: state <= MFR_ST_IGNORE;
            endcase
        end
    end

    // Mode nibble arrives on the first dummy rise; the second nibble is ignored.
    // A 4-line continuous-read entry keeps the address length of the read that set it.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            continuous_read_mode_out <= 1'b0;
            mode_bits_top_out        <= 4'h0;
            cont_addr4               <= 1'b0;
        end else if (!cs_s2 && state == MFR_ST_DUMMY && kind == MFR_KIND_QIO && rise && bit_cnt == 6'h00) begin
            mode_bits_top_out        <= io_s2;
            continuous_read_mode_out <= (io_s2 == `MFR_CONT_NIBBLE);
            cont_addr4               <= (addr_rises == `MFR_ADDR_4L_4B);
        end
    end

    // Prefetch runs from the end of the address phase; otherwise the buffer is held empty.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            fifo_flush <= 1'b1;
        end else begin
            fifo_flush <= cs_s2 || !(state == MFR_ST_DUMMY || state == MFR_ST_DATA);
        end
    end

    assign arr_fire = arr_valid_in & arr_ready_out;

    // Fetch address loads from the shifted address and wraps through zero at the top.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            arr_addr_out <= '0;
        end else if (addr_done && !cs_s2) begin
            arr_addr_out <= next_addr[ADDR_W-1:0];
        end else if (arr_fire) begin
            arr_addr_out <= arr_addr_out + ADDR_W'(1);
        end
    end

    mfr_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk_in    (ref_clk_in),
        .rst_b_in      (rst_b_in),
        .flush_in      (fifo_flush),
        .in_valid_in   (arr_valid_in),
        .in_data_in    (arr_data_in),
        .in_ready_out  (arr_ready_out),
        .out_valid_out (fifo_valid),
        .out_data_out  (fifo_data),
        .out_ready_in  (pop)
    );

    assign pop = fall && !cs_s2 && (state == MFR_ST_DATA) && (slot == 2'b00) && fifo_valid;

    // Output shifter: a new byte on the first fall of each byte, MSB on the highest line.
    // Lines are only enabled from the first data fall, so the host's last dummy bit is never contended.
    always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            io_out    <= 4'h0;
            io_oe_out <= 4'h0;
            byte_sr   <= 8'h00;
            slot      <= 2'b00;
        end else if (cs_s2 || state != MFR_ST_DATA) begin
            io_oe_out <= 4'h0;
            slot      <= 2'b00;
        end else if (fall) begin
            if (kind == MFR_KIND_DUAL) begin
                io_oe_out <= 4'h3;
                slot      <= slot + 2'b01;
                if (slot == 2'b00) begin
                    io_out  <= {2'b00, pop ? fifo_data[7:6] : 2'b11};
                    byte_sr <= pop ? {fifo_data[5:0], 2'b00} : `MFR_UNDERRUN_BYTE;
                end else begin
                    io_out  <= {2'b00, byte_sr[7:6]};
                    byte_sr <= {byte_sr[5:0], 2'b00};
                end
            end else begin
                io_oe_out <= 4'hf;
                slot      <= {1'b0, ~slot[0]};
                if (slot == 2'b00) begin
                    io_out  <= pop ? fifo_data[7:4] : 4'hf;
                    byte_sr <= pop ? {fifo_data[3:0], 4'h0} : `MFR_UNDERRUN_BYTE;
                end else begin
                    io_out  <= byte_sr[7:4];
                    byte_sr <= {byte_sr[3:0], 4'h0};
                end
            end
        end
    end

    // Checks on the sequencer and the pins it drives.
    sequence s_last_cmd_rise;
        !cs_s2 && state == MFR_ST_CMD && rise && bit_cnt == `MFR_CMD_CLKS - 6'h01;
    endsequence

    sequence s_select_idle;
        !cs_s2 && state == MFR_ST_IDLE;
    endsequence

    a_cs_release_oe: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        cs_s2 |=> io_oe_out == 4'h0 && state == MFR_ST_IDLE)
        else $error("Lines still driven after select went high.");

    a_wip_ignore: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_last_cmd_rise and write_in_progress_flag_in |=> state == MFR_ST_IGNORE)
        else $error("Read accepted while a write was in progress.");

    a_ignore_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        state == MFR_ST_IGNORE |-> io_oe_out == 4'h0 && $stable(arr_addr_out))
        else $error("Ignored read drove lines or moved the fetch address.");

    a_addr_len_4b: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_last_cmd_rise and opcode == `MFR_OP_DUAL_OUT_4B and !write_in_progress_flag_in
        |=> addr_rises == `MFR_ADDR_1L_4B && state == MFR_ST_ADDR)
        else $error("Four-byte dual read did not take 32 address clocks.");

    a_cont_skip: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s_select_idle and continuous_read_mode_out and !write_in_progress_flag_in
        |=> state == MFR_ST_ADDR && kind == MFR_KIND_QIO)
        else $error("Continuous read did not start at the address.");

    a_mode_exit: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !cs_s2 && state == MFR_ST_DUMMY && kind == MFR_KIND_QIO && rise && bit_cnt == 6'h00
        && io_s2 != `MFR_CONT_NIBBLE |=> !continuous_read_mode_out ##1 !continuous_read_mode_out)
        else $error("Continuous read kept after a foreign mode nibble.");

    a_dual_lanes: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !cs_s2 && state == MFR_ST_DATA && kind == MFR_KIND_DUAL && fall |=> io_oe_out == 4'h3)
        else $error("Dual read drove the wrong lines.");

    a_quad_lanes: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !cs_s2 && state == MFR_ST_DATA && kind != MFR_KIND_DUAL && fall |=> io_oe_out == 4'hf)
        else $error("Quad read drove the wrong lines.");

    a_fetch_wrap: assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        arr_fire && !addr_done && arr_addr_out == {ADDR_W{1'b1}} |=> arr_addr_out == '0)
        else $error("Fetch address did not wrap to zero.");
endmodule

`default_nettype wire

// file: sim/mfr_host.sv
/*
 * Host-side model of a serial flash controller issuing multi-line reads.
 * Assumes the bench resolves the shared lines, with pull-ups, into pin_in.
 */
`timescale 1ns/10ps
`default_nettype none

module mfr_host (
    output logic            sck_out,
    output logic            cs_b_out,
    output logic      [3:0] drv_out,
    output logic      [3:0] drv_oe_out,
    input  wire logic [3:0] pin_in
);
    logic [7:0] rx[$];
    int         stall_ns = 0;

    // Idle bus: select high, clock parked low, lines released.
    initial begin
        sck_out = 1'b0;
        cs_b_out = 1'b1;
        drv_out = 4'h0;
        drv_oe_out = 4'h0;
    end

    // One link clock: drive in the low phase, sample at the rise.
    task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] s);
        drv_out = v;
        drv_oe_out = oe;
        #62.5 sck_out = 1'b1;
        s = pin_in;
        #62.5 sck_out = 1'b0;
    endtask

    // A whole read; a stall holds the clock still so the device buffer fills.
    task automatic rd(input logic [7:0] op, input logic [31:0] a, input int ab, input int k,
                      input int dum, input bit skip, input logic [3:0] md, input int n);
        logic [3:0] s;
        logic [7:0] b;
        rx.delete();
        cs_b_out = 1'b0;
        #100;
        if (!skip) for (int i = 7; i >= 0; i--) tick({3'b000, op[i]}, 4'h1, s);
        if (k == 2) for (int i = 2 * ab - 1; i >= 0; i--) tick(a[4*i+:4], 4'hf, s);
        else for (int i = 8 * ab - 1; i >= 0; i--) tick({3'b000, a[i]}, 4'h1, s);
        for (int i = 0; i < dum; i++) tick(md, (k == 2 && i == 0) ? 4'hf : 4'h0, s);
        #(stall_ns);
        for (int j = 0; j < n; j++) begin
            for (int i = 0; i < ((k == 0) ? 4 : 2); i++) begin
                tick(4'h0, 4'h0, s);
                b = (k == 0) ? {b[5:0], s[1:0]} : {b[3:0], s};
            end
            rx.push_back(b);
        end
        #62.5 cs_b_out = 1'b1;
        drv_oe_out = 4'h0;
        #100;
    endtask
endmodule

`default_nettype wire

// file: sim/tb_mfr_engine.sv
/*
 * Self-checking bench of the multi-line flash read engine.
 * Assumes the host model sim/mfr_host.sv and the design package are compiled first.
 */
`timescale 1ns/10ps
`default_nettype none

module tb_mfr_engine;
    import mfr_pkg::*;
    logic        ref_clk, rst_b, write_in_progress_flag, arr_valid, sck, cs_b, arr_ready, cont, oe_seen, quiet;
    mfr_rd_cfg_t cfg;
    logic  [3:0] io_out, io_oe, drv, drv_oe, mode_top;
    wire logic [3:0] pin;
    logic [23:0] arr_addr, a0;
    logic  [7:0] arr_data;
    int          miscompares, tests_run, seed;

    // Array contents as a plain function of the address.
    function automatic logic [7:0] f(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16] ^ 8'h96;
    endfunction

    // Shared lines carry pull-ups, so a released line reads high.
    assign pin = (io_oe & io_out) | (~io_oe & drv_oe & drv) | (~io_oe & ~drv_oe);
    assign arr_data = f(arr_addr);

    mfr_engine #(.ADDR_W(24), .FIFO_DEPTH(8)) dut (
        .ref_clk_in(ref_clk), .rst_b_in(rst_b), .sck_in(sck), .cs_b_in(cs_b), .io_in(pin),
        .io_out(io_out), .io_oe_out(io_oe), .write_in_progress_flag_in(write_in_progress_flag), .cfg_in(cfg),
        .arr_addr_out(arr_addr), .arr_valid_in(arr_valid), .arr_data_in(arr_data),
        .arr_ready_out(arr_ready), .continuous_read_mode_out(cont), .mode_bits_top_out(mode_top));

    mfr_host host (.sck_out(sck), .cs_b_out(cs_b), .drv_out(drv), .drv_oe_out(drv_oe), .pin_in(pin));

    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // The array answers at random, so the buffer sees stalls and bursts.
    always @(posedge ref_clk) begin
        arr_valid <= ($random(seed) & 1) != 0;
        if ((write_in_progress_flag || quiet) && io_oe != 4'h0) oe_seen <= 1'b1;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic run(input logic [7:0] op, input logic ext, input logic [3:0] dcfg, input logic [31:0] a,
                       input int ab, input int k, input int dum, input bit skip, input logic [3:0] md, input int n);
        @(posedge ref_clk);
        cfg <= {ext, dcfg, 4'h0};
        host.rd(op, a, ab, k, dum, skip, md, n);
        repeat (10) @(posedge ref_clk);
        chk("oe_after_select", 4'h0, io_oe);
        for (int i = 0; i < n; i++) chk("data", f(24'(a + i)), host.rx[i]);
    endtask

    task automatic print_verdict;
        if (miscompares == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // A hang is cut short at 400 us, well beyond the 95 us or so the reads need.
    initial begin
        #400000;
        miscompares++;
        print_verdict();
    end

    initial begin
        seed = 81;
        rst_b = 1'b0;
        write_in_progress_flag = 1'b0;
        cfg = '0;
        arr_valid = 1'b0;
        oe_seen = 1'b0;
        quiet = 1'b0;
        miscompares = 0;
        tests_run = 0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge ref_clk);
        chk("cont_reset", 0, cont);
        run(8'h3b, 1'b0, 4'h0, $random(seed), 3, 0, 8, 0, 4'h0, 5);
        run(8'h3c, 1'b0, 4'h4, $random(seed), 4, 0, 4, 0, 4'h0, 4);
        run(8'h3b, 1'b1, 4'h0, 32'h00fffffe, 4, 0, 8, 0, 4'h0, 4);
        run(8'h6b, 1'b0, 4'h0, $random(seed), 3, 1, 8, 0, 4'h0, 5);
        run(8'h6c, 1'b0, 4'h0, $random(seed), 4, 1, 8, 0, 4'h0, 3);
        run(8'h6b, 1'b1, 4'h0, $random(seed), 4, 1, 8, 0, 4'h0, 3);
        run(8'heb, 1'b0, 4'h0, $random(seed), 3, 2, 6, 0, 4'ha, 4);
        chk("cont_on", 1, cont);
        chk("mode_top", 4'ha, mode_top);
        run(8'heb, 1'b0, 4'h0, $random(seed), 3, 2, 6, 1, 4'h5, 4);
        chk("cont_off", 0, cont);
        run(8'hec, 1'b0, 4'h0, $random(seed), 4, 2, 6, 0, 4'h0, 3);
        run(8'heb, 1'b1, 4'h0, $random(seed), 4, 2, 6, 0, 4'h3, 3);
        // Host stalls after the dummy clocks: the buffer must fill and refuse, then drain.
        host.stall_ns = 3000;
        fork
            run(8'h3b, 1'b0, 4'h0, $random(seed), 3, 0, 8, 0, 4'h0, 10);
            begin
                @(negedge cs_b);
                #7105;
                chk("buffer_full", 0, arr_ready);
            end
        join
        host.stall_ns = 0;
        // Busy at a continuous-read select: the read is dropped, mode and fetch address kept.
        run(8'heb, 1'b0, 4'h0, $random(seed), 3, 2, 6, 0, 4'ha, 2);
        @(posedge ref_clk);
        write_in_progress_flag <= 1'b1;
        a0 = arr_addr;
        host.rd(8'heb, $random(seed), 3, 2, 6, 1, 4'h5, 2);
        chk("busy_cont_mode", 1, cont);
        chk("busy_cont_addr", a0, arr_addr);
        write_in_progress_flag <= 1'b0;
        run(8'heb, 1'b0, 4'h0, $random(seed), 3, 2, 6, 1, 4'h0, 2);
        chk("cont_left", 0, cont);
        @(posedge ref_clk);
        write_in_progress_flag <= 1'b1;
        a0 = arr_addr;
        host.rd(8'h3b, $random(seed), 3, 0, 8, 0, 4'h0, 2);
        chk("busy_drive", 0, oe_seen);
        chk("busy_addr", a0, arr_addr);
        chk("busy_mode", 0, cont);
        write_in_progress_flag <= 1'b0;
        // An opcode outside the six is dropped the same way; the lines stay released.
        @(posedge ref_clk);
        quiet <= 1'b1;
        a0 = arr_addr;
        host.rd(8'h0b, $random(seed), 3, 0, 8, 0, 4'h0, 2);
        chk("foreign_drive", 0, oe_seen);
        chk("foreign_addr", a0, arr_addr);
        quiet <= 1'b0;
        print_verdict();
    end
endmodule

`default_nettype wire
